// ==== irq_host_model.sv ====
// Far-side model: the interrupt inputs of the CPU that takes line B and the external pin.
// Assumes it samples on clk and is told the pin polarity that software programmed.
`timescale 1ns/1ps

module irq_host_model
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic line_b,
   input wire logic ext_pin,
   input wire logic pin_active_high,
   output logic line_b_req,
   output logic ext_req
);
   // Polarity is undone at the pin only, so requests are active high inside
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         line_b_req <= 1'b0;
         ext_req <= 1'b0;
      end
      else
      begin
         line_b_req <= line_b;
         ext_req <= (ext_pin == pin_active_high);
      end
   end
endmodule : irq_host_model

// ==== irq_ident_pkg.sv ====
// Constants for the interrupt source identification and routing block.
// Assumes a 32-bit APB register bus and one system clock.
package irq_ident_pkg;

   // Register byte offsets
   localparam logic [7:0] cpu_line_b_enable_off = 8'h00;
   localparam logic [7:0] cpu_line_b_source_vector_off = 8'h04;
   localparam logic [7:0] external_line_enable_off = 8'h08;
   localparam logic [7:0] external_line_source_vector_off = 8'h0c;
   localparam logic [7:0] per_device_interrupt_vector_off = 8'h10;
   localparam logic [7:0] dest_select_lo_off = 8'h14;
   localparam logic [7:0] dest_select_hi_off = 8'h18;
   localparam logic [7:0] event_status_off = 8'h1c;
   localparam logic [7:0] event_mask_off = 8'h20;
   localparam logic [7:0] pin_config_off = 8'h24;

   // Source bit positions in the line B and external identification vectors
   localparam int mgmt_serial_ctrl_1_bit = 28;
   localparam int mgmt_serial_ctrl_0_bit = 27;
   localparam int integrity_fault_bit = 25;
   localparam int frame_inject_ready_1_bit = 21;
   localparam int frame_inject_ready_0_bit = 20;
   localparam int frame_extract_ready_1_bit = 17;
   localparam int frame_extract_ready_0_bit = 16;
   localparam int analyzer_block_bit = 15;
   localparam int aggregate_device_source_bit = 14;
   localparam int serial_gpio_bit = 13;
   localparam int gpio_bit = 12;
   localparam int two_wire_iface_bit = 11;
   localparam int timer_2_bit = 9;
   localparam int timer_1_bit = 8;
   localparam int timer_0_bit = 7;
   localparam int uart_bit = 6;
   localparam int software_irq_1_bit = 3;
   localparam int software_irq_0_bit = 2;
   localparam int external_input_bit = 0;

   // Bits that carry a source; all others read as zero
   localparam logic [31:0] source_present_mask = 32'h1a33_fbcd;

   // Field positions and reset values
   localparam int enable_bit = 0;
   localparam int pin_polarity_bit = 0;
   localparam logic [31:0] vector_reset = 32'h0000_0000;
   localparam logic [63:0] dest_select_reset = 64'h0000_0000_0000_0000;
   localparam logic [2:0] event_reset = 3'h0;

   // Event status bits
   localparam int ev_line_b_bit = 0;
   localparam int ev_external_bit = 1;
   localparam int ev_device_bit = 2;

   // Destination selector codes
   typedef enum logic [1:0]
   {
      dest_cpu_line_a = 2'b00,
      dest_cpu_line_b = 2'b01,
      dest_external = 2'b10,
      dest_none = 2'b11
   } dest_e;

endpackage : irq_ident_pkg

// ==== irq_source_ident_routing.sv ====
// Interrupt source identification and routing for the second CPU line and the external line.
// Assumes pending source levels arrive already conditioned (sticky, forced, bypassed) and synchronous to clk.
//
// The APB interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps

module irq_source_ident_routing
   import irq_ident_pkg::*;
#(
   parameter int device_count = 32
)
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic clk_en,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [31:0] source_pending,
   input wire logic [device_count-1:0] device_irq,
   output logic cpu_irq_line_b,
   output logic external_irq_pin,
   output logic external_irq_pin_oe,
   output logic aggregate_device_source,
   output logic irq
);

   ////////////////////////////////////////////////////////////////////////////
   // Register state

   logic cpu_line_b_enable_bit;
   logic external_line_enable_bit;
   logic pin_active_high;
   logic [31:0] cpu_line_b_source_vector;
   logic [31:0] external_line_source_vector;
   logic [31:0] per_device_vector_field;
   logic [63:0] dest_select;
   logic [2:0] event_status;
   logic [2:0] event_mask;
   logic [2:0] prev_event;
   logic [31:0] route_b;
   logic [31:0] route_ext;
   logic [31:0] merged_pending;
   logic [31:0] next_rdata;
   logic next_slverr;
   logic [2:0] event_now;
   logic [2:0] event_rise;
   logic setup_phase;
   logic wr_access;
   logic addr_hit;

   assign setup_phase = psel && !penable;
   assign wr_access = psel && penable && pwrite && clk_en;

   ////////////////////////////////////////////////////////////////////////////
   // Routing decode, one selector per source

   genvar gi;
   generate
      for (gi = 0; gi < 32; gi++)
      begin : g_route
         assign route_b[gi] = (dest_e'(dest_select[2*gi +: 2]) == dest_cpu_line_b);
         assign route_ext[gi] = (dest_e'(dest_select[2*gi +: 2]) == dest_external);
      end
   endgenerate

   // Aggregate device bit replaces whatever the source input carries there
   always_comb
   begin
      merged_pending = source_pending & source_present_mask;
      merged_pending[aggregate_device_source_bit] = aggregate_device_source;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Identification vectors

   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         cpu_line_b_source_vector <= vector_reset;
         external_line_source_vector <= vector_reset;
      end
      else if (clk_en)
      begin
         cpu_line_b_source_vector <= merged_pending & route_b;
         external_line_source_vector <= merged_pending & route_ext;
      end
   end

   // Device vector zero-extends when fewer than 32 devices are built
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         per_device_vector_field <= vector_reset;
      end
      else if (clk_en)
      begin
         per_device_vector_field <= 32'(device_irq);
      end
   end

   assign aggregate_device_source = |per_device_vector_field;

   ////////////////////////////////////////////////////////////////////////////
   // Output lines; active high inside, inverted at the pin only when polarity is active low

   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         cpu_irq_line_b <= 1'b0;
         // Polarity resets to active low, so the idle pin level is high
         external_irq_pin <= 1'b1;
      end
      else if (clk_en)
      begin
         cpu_irq_line_b <= cpu_line_b_enable_bit && (|cpu_line_b_source_vector);
         external_irq_pin <= !((external_line_enable_bit && (|external_line_source_vector)) ^ pin_active_high);
      end
   end

   // Pin is always driven so an inactive level is defined in both polarities
   assign external_irq_pin_oe = 1'b1;

   ////////////////////////////////////////////////////////////////////////////
   // Control registers

   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         cpu_line_b_enable_bit <= 1'b0;
         external_line_enable_bit <= 1'b0;
         pin_active_high <= 1'b0;
         dest_select <= dest_select_reset;
         event_mask <= event_reset;
      end
      else if (wr_access)
      begin
         unique case (paddr)
            cpu_line_b_enable_off: cpu_line_b_enable_bit <= pwdata[enable_bit];
            external_line_enable_off: external_line_enable_bit <= pwdata[enable_bit];
            pin_config_off: pin_active_high <= pwdata[pin_pol_sel()];
            dest_select_lo_off: dest_select[31:0] <= pwdata;
            dest_select_hi_off: dest_select[63:32] <= pwdata;
            event_mask_off: event_mask <= pwdata[2:0];
            default: ;
         endcase
      end
   end

   function automatic int pin_pol_sel();
      return pin_polarity_bit;
   endfunction : pin_pol_sel

   ////////////////////////////////////////////////////////////////////////////
   // Sticky events on rising output lines; a new event beats a same-cycle clear

   assign event_now = {aggregate_device_source, external_line_enable_bit && (|external_line_source_vector),
                       cpu_irq_line_b};
   assign event_rise = event_now & ~prev_event;

   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         prev_event <= event_reset;
         event_status <= event_reset;
      end
      else if (clk_en)
      begin
         prev_event <= event_now;
         if (wr_access && paddr == event_status_off)
         begin
            event_status <= (event_status & ~pwdata[2:0]) | event_rise;
         end
         else
         begin
            event_status <= event_status | event_rise;
         end
      end
   end

   assign irq = |(event_status & event_mask);

   ////////////////////////////////////////////////////////////////////////////
   // APB read path; data is captured in the setup cycle, answer in the first access cycle

   always_comb
   begin
      next_rdata = 32'h0000_0000;
      addr_hit = 1'b1;
      unique case (paddr)
         cpu_line_b_enable_off: next_rdata[enable_bit] = cpu_line_b_enable_bit;
         cpu_line_b_source_vector_off: next_rdata = cpu_line_b_source_vector;
         external_line_enable_off: next_rdata[enable_bit] = external_line_enable_bit;
         external_line_source_vector_off: next_rdata = external_line_source_vector;
         per_device_interrupt_vector_off: next_rdata = per_device_vector_field;
         dest_select_lo_off: next_rdata = dest_select[31:0];
         dest_select_hi_off: next_rdata = dest_select[63:32];
         event_status_off: next_rdata[2:0] = event_status;
         event_mask_off: next_rdata[2:0] = event_mask;
         pin_config_off: next_rdata[pin_polarity_bit] = pin_active_high;
         default: addr_hit = 1'b0;
      endcase
      next_slverr = !addr_hit || (paddr[1:0] != 2'b00);
   end

   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         prdata <= vector_reset;
         pslverr <= 1'b0;
      end
      else if (clk_en && setup_phase)
      begin
         prdata <= pwrite ? vector_reset : next_rdata;
         pslverr <= next_slverr;
      end
   end

   // Frozen clock enable holds the access phase open
   assign pready = psel && penable && clk_en;

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   sequence apb_write_s(logic [7:0] a);
      psel && !penable && pwrite && paddr == a ##1 psel && penable && clk_en;
   endsequence

   sequence enabled_cycle_s;
      clk_en ##1 clk_en;
   endsequence

   property route_follows_p(logic [31:0] vec, logic [31:0] rt);
      @(posedge clk) disable iff (!resetn)
         clk_en |=> vec == ($past(merged_pending) & $past(rt));
   endproperty

   line_b_route_a: assert property (route_follows_p(cpu_line_b_source_vector, route_b))
      else $error("line B vector does not match pending and route");

   ext_route_a: assert property (route_follows_p(external_line_source_vector, route_ext))
      else $error("external vector does not match pending and route");

   vectors_disjoint_a: assert property (@(posedge clk) disable iff (!resetn)
      (cpu_line_b_source_vector & external_line_source_vector) == 32'h0000_0000)
      else $error("a source is routed to two lines");

   unused_bits_zero_a: assert property (@(posedge clk) disable iff (!resetn)
      ((cpu_line_b_source_vector | external_line_source_vector) & ~source_present_mask) == 32'h0000_0000)
      else $error("identification bit set where no source exists");

   aggregate_or_a: assert property (@(posedge clk) disable iff (!resetn)
      enabled_cycle_s |-> aggregate_device_source == ($past(device_irq) != '0))
      else $error("aggregate source does not match device inputs");

   line_b_gate_a: assert property (@(posedge clk) disable iff (!resetn)
      clk_en && !cpu_line_b_enable_bit |=> !cpu_irq_line_b)
      else $error("line B asserted while disabled");

   ext_pin_level_a: assert property (@(posedge clk) disable iff (!resetn)
      clk_en |=> external_irq_pin == !(($past(external_line_enable_bit) &&
         ($past(external_line_source_vector) != 32'h0000_0000)) ^ $past(pin_active_high)))
      else $error("external pin level wrong for enable and polarity");

   ext_enable_write_a: assert property (@(posedge clk) disable iff (!resetn)
      apb_write_s(external_line_enable_off) |=> external_line_enable_bit == $past(pwdata[enable_bit]))
      else $error("external enable write not taken");

   ro_write_ignored_a: assert property (@(posedge clk) disable iff (!resetn)
      apb_write_s(per_device_interrupt_vector_off) |=> per_device_vector_field == 32'($past(device_irq)))
      else $error("write disturbed the device vector");

   sticky_set_wins_a: assert property (@(posedge clk) disable iff (!resetn)
      clk_en && event_rise[ev_line_b_bit] |=> event_status[ev_line_b_bit])
      else $error("line B event lost");

   line_b_level_a: assert property (@(posedge clk) disable iff (!resetn)
      clk_en |=> cpu_irq_line_b == ($past(cpu_line_b_enable_bit) &&
         ($past(cpu_line_b_source_vector) != 32'h0000_0000)))
      else $error("line B level does not follow enable and vector");

   line_b_write_a: assert property (@(posedge clk) disable iff (!resetn)
      apb_write_s(cpu_line_b_enable_off) |=> cpu_line_b_enable_bit == $past(pwdata[enable_bit]))
      else $error("line B enable write not taken");

   device_vector_a: assert property (@(posedge clk) disable iff (!resetn)
      clk_en |=> per_device_vector_field == 32'($past(device_irq)))
      else $error("device vector does not follow device inputs");

   aggregate_ident_a: assert property (@(posedge clk) disable iff (!resetn)
      clk_en |=> cpu_line_b_source_vector[aggregate_device_source_bit] ==
         ($past(aggregate_device_source) && $past(route_b[aggregate_device_source_bit])))
      else $error("aggregate source missing from line B vector");

   ro_ident_write_a: assert property (@(posedge clk) disable iff (!resetn)
      apb_write_s(cpu_line_b_source_vector_off) |=> cpu_line_b_source_vector == ($past(merged_pending) & $past(route_b)))
      else $error("write disturbed the line B vector");

   ext_gate_idle_a: assert property (@(posedge clk) disable iff (!resetn)
      clk_en && !external_line_enable_bit |=> external_irq_pin != $past(pin_active_high))
      else $error("external pin active while disabled");

   dest_write_a: assert property (@(posedge clk) disable iff (!resetn)
      apb_write_s(dest_select_lo_off) |=> dest_select[31:0] == $past(pwdata))
      else $error("selector write not taken");

   status_clear_a: assert property (@(posedge clk) disable iff (!resetn)
      clk_en && wr_access && paddr == event_status_off && pwdata[ev_line_b_bit] && !event_rise[ev_line_b_bit]
         |=> !event_status[ev_line_b_bit])
      else $error("line B event not cleared");

   unmapped_error_a: assert property (@(posedge clk) disable iff (!resetn)
      psel && !penable && clk_en && (paddr > pin_config_off || paddr[1:0] != 2'b00) |=> pslverr)
      else $error("unmapped access without error response");

endmodule : irq_source_ident_routing

// ==== testbench.sv ====
// Self-checking bench: APB register tasks plus source and device interrupt stimulus.
// Assumes one 100 MHz clock and the register map of the package.
`timescale 1ns/1ps

module testbench
   import irq_ident_pkg::*;
;
   logic clk, resetn, clk_en, psel, penable, pwrite, pready, pslverr, err, pol;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd, source_pending, device_irq;
   logic cpu_irq_line_b, external_irq_pin, external_irq_pin_oe, aggregate_device_source, irq;
   logic line_b_req, ext_req;
   int mismatches, n_checks, cycles;
   // Bit 14 comes from the device vector, never from the pending input
   localparam logic [31:0] src_exp = source_present_mask & ~(32'h1 << aggregate_device_source_bit);

   irq_source_ident_routing #(.device_count(32)) u_irq_source_ident_routing (.clk(clk), .resetn(resetn),
      .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .source_pending(source_pending),
      .device_irq(device_irq), .cpu_irq_line_b(cpu_irq_line_b), .external_irq_pin(external_irq_pin),
      .external_irq_pin_oe(external_irq_pin_oe), .aggregate_device_source(aggregate_device_source), .irq(irq));
   irq_host_model u_irq_host_model (.clk(clk), .resetn(resetn), .line_b(cpu_irq_line_b),
      .ext_pin(external_irq_pin), .pin_active_high(pol), .line_b_req(line_b_req), .ext_req(ext_req));

   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // A hang ends here rather than stalling the run
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         mismatches++;
         finish_test();
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic finish_test();
      $display("mismatches %0d checks %0d", mismatches, n_checks);
      if (mismatches == 0 && n_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : finish_test

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   // Setup cycle, then access until pready is seen high at a rising edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1)
      begin
         @(posedge clk);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      check(rd, exp);
   endtask : rd_chk

   task automatic route(input logic [31:0] codes);
      apb(1'b1, dest_select_lo_off, codes);
      apb(1'b1, dest_select_hi_off, codes);
      repeat (4) @(posedge clk);
   endtask : route

   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      resetn = 1'b0;
      clk_en = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      source_pending = 32'h0;
      device_irq = 32'h0;
      pol = 1'b0;
      repeat (10) @(posedge clk);
      resetn <= 1'b1;
      for (int i = 0; i < 10; i++)
      begin
         rd_chk(8'(i * 4), vector_reset);
      end
      apb(1'b0, 8'h28, 32'h0);
      check({31'h0, err}, 32'h1);
      apb(1'b1, cpu_line_b_source_vector_off, 32'hffff_ffff);
      rd_chk(cpu_line_b_source_vector_off, 32'h0);
      // Every input bit high, so unused positions must stay clear
      source_pending <= 32'hffff_ffff;
      route(32'h5555_5555);
      rd_chk(cpu_line_b_source_vector_off, src_exp);
      rd_chk(external_line_source_vector_off, 32'h0);
      check({31'h0, line_b_req}, 32'h0);
      apb(1'b1, cpu_line_b_enable_off, 32'h1);
      repeat (4) @(posedge clk);
      check({31'h0, line_b_req}, 32'h1);
      route(32'haaaa_aaaa);
      rd_chk(external_line_source_vector_off, src_exp);
      rd_chk(cpu_line_b_source_vector_off, 32'h0);
      check({30'h0, cpu_irq_line_b, ext_req}, 32'h0);
      apb(1'b1, external_line_enable_off, 32'h1);
      repeat (4) @(posedge clk);
      check({30'h0, ext_req, external_irq_pin}, 32'h2);
      check({31'h0, external_irq_pin_oe}, 32'h1);
      apb(1'b1, pin_config_off, 32'h1);
      pol <= 1'b1;
      repeat (4) @(posedge clk);
      check({30'h0, ext_req, external_irq_pin}, 32'h3);
      device_irq <= 32'h8000_0001;
      repeat (4) @(posedge clk);
      rd_chk(per_device_interrupt_vector_off, 32'h8000_0001);
      check({31'h0, aggregate_device_source}, 32'h1);
      // Frozen clock enable must hold the device vector
      clk_en <= 1'b0;
      device_irq <= 32'h0;
      repeat (4) @(posedge clk);
      check({31'h0, aggregate_device_source}, 32'h1);
      device_irq <= 32'h8000_0001;
      clk_en <= 1'b1;
      rd_chk(external_line_source_vector_off, source_present_mask);
      apb(1'b1, per_device_interrupt_vector_off, 32'h0);
      rd_chk(per_device_interrupt_vector_off, 32'h8000_0001);
      route(32'hffff_ffff);
      rd_chk(external_line_source_vector_off, 32'h0);
      check({31'h0, irq}, 32'h0);
      rd_chk(event_status_off, 32'h7);
      apb(1'b1, event_mask_off, 32'h7);
      repeat (2) @(posedge clk);
      check({31'h0, irq}, 32'h1);
      apb(1'b1, event_status_off, 32'h7);
      rd_chk(event_status_off, 32'h0);
      check({31'h0, irq}, 32'h0);
      finish_test();
   end
endmodule : testbench
